// >>> logic/pdsf_pkg.sv
// package for the pwm dead-band, sync, fault and output stage
// assumes a single 250 MHz pwm clock with synchronous reset
package pdsf_pkg;
	localparam int unsigned NUM_GEN = 2;
	localparam int unsigned NUM_OUT = 4;
	localparam int unsigned NUM_FLT = 4;
	localparam int unsigned NUM_EVT = 6;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned CLK_MHZ = 250;
	// event field positions within a generator's event vector
	localparam int unsigned EVT_ZERO = 0;
	localparam int unsigned EVT_LOAD = 1;
	localparam int unsigned EVT_A_UP = 2;
	localparam int unsigned EVT_A_DN = 3;
	localparam int unsigned EVT_B_UP = 4;
	localparam int unsigned EVT_B_DN = 5;
	// generator control field positions
	localparam int unsigned CTL_GLOBAL_UPD = 0;
	localparam int unsigned CTL_ALL_FLT = 1;
	localparam int unsigned CTL_LATCH = 2;
	localparam int unsigned CTL_MINPER_EN = 3;
	localparam int unsigned CTL_W = 4;
	localparam logic [CTL_W-1:0] CTL_RESET = 4'h0;
	localparam logic [CNT_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [1:0] UPD_MODE_RESET = 2'h0;

	// update mode of a synchronised register
	typedef enum logic [1:0] {
		PDSF_UPD_IMMED,
		PDSF_UPD_LOCAL,
		PDSF_UPD_GLOBAL
	} pdsf_upd_e;

	// dead-band settings of one generator
	typedef struct packed {
		logic enable;
		logic [CNT_W-1:0] rise;
		logic [CNT_W-1:0] fall;
	} pdsf_db_s;

	// period and compare words of one generator
	typedef struct packed {
		logic [CNT_W-1:0] load;
		logic [CNT_W-1:0] cmpa;
		logic [CNT_W-1:0] cmpb;
	} pdsf_tim_s;
endpackage

// >>> logic/pdsf_output_stage.sv
// How it works
// RQ1: dead-band off passes both raw signals unchanged
// RQ2: dead-band on: first output delays first rise
// RQ3: second output inverted, rise delayed by fall
// RQ4: selected events OR into irq and adc trigger
// RQ5: irq and trigger use undelayed raw events
// RQ6: sync write zeroes selected counters together
// RQ7: immediate mode applies writes at once
// RQ8: local mode applies pending value at zero
// RQ9: global mode waits update bit then zero
// RQ10: load and compares use local or global
// RQ11: gate, edge, dead-band optional sync, immediate default
// RQ12: fault from pins or debug stall, per generator
// RQ13: control picks fault zero only or all
// RQ14: fault follows input or latches until cleared
// RQ15: minimum fault period stretches external faults
// RQ16: four fault pins with programmable polarity
// RQ17: source select ORs corrected chosen inputs
// RQ18: cause register shows which input faulted
// RQ19: module irq enable promotes fault to interrupt
// RQ20: configured outputs drive fault value during fault
// RQ21: output gate enables each pin independently
// RQ22: per-output inversion is the final step
// RQ23: events: zero, load, compare up and down
// RQ24: delays counted in clocks, faults synchronised
//
// back end of a two-generator pwm unit; counters and edge-action logic
// sit outside and feed raw signals and events in; registers are ports
// whose write strobes are one-cycle pulses
`timescale 1ns/1ns
module pdsf_output_stage #(
	parameter int unsigned NUM_GEN = pdsf_pkg::NUM_GEN,
	parameter int unsigned NUM_FLT = pdsf_pkg::NUM_FLT,
	parameter int unsigned CW = pdsf_pkg::CNT_W
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [2*NUM_GEN-1:0] i_raw_signal,
	input wire logic [NUM_GEN*pdsf_pkg::NUM_EVT-1:0] i_counter_event,
	input wire logic [NUM_GEN-1:0] i_updown_mode,
	input wire logic [NUM_FLT-1:0] i_fault_input_pin,
	input wire logic i_debug_stall,
	input wire logic [NUM_GEN-1:0] i_stall_fault_en,
	input wire logic i_time_base_sync_wr,
	input wire logic [NUM_GEN-1:0] i_time_base_sync_reg,
	input wire logic [NUM_GEN*pdsf_pkg::CTL_W-1:0] i_generator_control_reg,
	input wire logic [NUM_GEN-1:0] i_global_update_set,
	input wire logic [NUM_GEN-1:0] i_tim_wr,
	input wire pdsf_pkg::pdsf_tim_s [NUM_GEN-1:0] i_tim_wdata,
	input wire logic [NUM_GEN-1:0] i_db_wr,
	input wire pdsf_pkg::pdsf_db_s [NUM_GEN-1:0] i_db_wdata,
	input wire logic [NUM_GEN*2-1:0] i_db_upd_mode,
	input wire logic i_gate_wr,
	input wire logic [2*NUM_GEN-1:0] i_output_gate_reg,
	input wire logic [1:0] i_gate_upd_mode,
	input wire logic [2*NUM_GEN-1:0] i_invert_reg,
	input wire logic [2*NUM_GEN-1:0] i_fault_override_select_reg,
	input wire logic [2*NUM_GEN-1:0] i_fault_drive_value_reg,
	input wire logic [NUM_GEN*NUM_FLT-1:0] i_fault_source_select_reg,
	input wire logic [NUM_FLT-1:0] i_fault_polarity_reg,
	input wire logic [NUM_GEN*CW-1:0] i_min_fault_duration_reg,
	input wire logic [NUM_GEN-1:0] i_fault_clear,
	input wire logic [NUM_GEN-1:0] i_module_irq_enable_reg,
	input wire logic [NUM_GEN*pdsf_pkg::NUM_EVT-1:0] i_irq_event_sel,
	input wire logic [NUM_GEN*pdsf_pkg::NUM_EVT-1:0] i_adc_event_sel,
	output logic [2*NUM_GEN-1:0] o_pwm_pin,
	output logic [NUM_GEN-1:0] o_counter_reset,
	output pdsf_pkg::pdsf_tim_s [NUM_GEN-1:0] o_tim_active,
	output logic [NUM_GEN-1:0] o_gen_irq,
	output logic [NUM_GEN-1:0] o_adc_trigger,
	output logic o_fault_irq,
	output logic [NUM_GEN-1:0] o_fault_active,
	output logic [NUM_GEN*NUM_FLT-1:0] o_fault_cause_reg
);
	localparam int unsigned NE = pdsf_pkg::NUM_EVT;
	localparam int unsigned NO = 2 * NUM_GEN;

	initial begin
		if (NUM_GEN < 1 || NUM_FLT < 1 || NUM_FLT > pdsf_pkg::NUM_FLT ||
		    CW < 2)
			$error("pdsf_output_stage: unsupported parameters");
	end

	// fault pins pass a two-flop synchroniser before any use
	logic [NUM_FLT-1:0] flt_meta_reg;
	logic [NUM_FLT-1:0] flt_sync_reg;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			flt_meta_reg <= '0;
			flt_sync_reg <= '0;
		end else begin
			flt_meta_reg <= i_fault_input_pin; // RQ24
			flt_sync_reg <= flt_meta_reg;
		end
	end
	logic [NUM_FLT-1:0] flt_true;
	assign flt_true = flt_sync_reg ^ i_fault_polarity_reg; // RQ16

	// output gate with optional sync to generator zero of gen 0
	logic [NO-1:0] gate_reg;
	logic [NO-1:0] gate_pend_reg;
	logic gate_busy_reg;
	logic gate_armed_reg;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			gate_reg <= '0;
			gate_pend_reg <= '0;
			gate_busy_reg <= 1'b0;
			gate_armed_reg <= 1'b0;
		end else if (i_gate_wr &&
		             i_gate_upd_mode == pdsf_pkg::PDSF_UPD_IMMED) begin
			gate_reg <= i_output_gate_reg; // RQ11
			gate_busy_reg <= 1'b0;
		end else if (i_gate_wr) begin
			gate_pend_reg <= i_output_gate_reg;
			gate_busy_reg <= 1'b1;
			gate_armed_reg <= (i_gate_upd_mode == pdsf_pkg::PDSF_UPD_LOCAL);
		end else begin
			if (i_global_update_set[0])
				gate_armed_reg <= 1'b1;
			if (gate_busy_reg && gate_armed_reg &&
			    i_counter_event[pdsf_pkg::EVT_ZERO]) begin
				gate_reg <= gate_pend_reg;
				gate_busy_reg <= 1'b0;
			end
		end
	end

	logic [NO-1:0] pin_next;
	logic [NUM_GEN-1:0] flt_any;

	genvar g;
	generate
		for (g = 0; g < NUM_GEN; g++) begin : gen_blk
			logic [pdsf_pkg::CTL_W-1:0] ctl;
			logic [NE-1:0] evt;
			logic zero_evt;
			assign ctl = i_generator_control_reg[g*pdsf_pkg::CTL_W +:
			                                     pdsf_pkg::CTL_W];
			// six events; match-up events are zero in down mode
			assign evt = i_updown_mode[g] ? i_counter_event[g*NE +: NE] :
			             (i_counter_event[g*NE +: NE] &
			              6'h2B); // RQ23
			assign zero_evt = evt[pdsf_pkg::EVT_ZERO];

			// counter reset from the sync write; irq and adc trigger from raw events
			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					o_counter_reset[g] <= 1'b0;
					o_gen_irq[g] <= 1'b0;
					o_adc_trigger[g] <= 1'b0;
				end else begin
					o_counter_reset[g] <= i_time_base_sync_wr &
					                      i_time_base_sync_reg[g]; // RQ6
					o_gen_irq[g] <= |(evt & i_irq_event_sel[g*NE +: NE]); // RQ4 RQ5
					o_adc_trigger[g] <= |(evt & i_adc_event_sel[g*NE +: NE]); // RQ4
				end
			end

			// load and compares: local or global by control bit
			pdsf_pkg::pdsf_tim_s tim_pend_reg;
			logic tim_busy_reg;
			logic tim_armed_reg;
			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					o_tim_active[g] <= '0;
					tim_pend_reg <= '0;
					tim_busy_reg <= 1'b0;
					tim_armed_reg <= 1'b0;
				end else if (i_tim_wr[g]) begin
					tim_pend_reg <= i_tim_wdata[g]; // RQ10
					tim_busy_reg <= 1'b1;
					tim_armed_reg <= ~ctl[pdsf_pkg::CTL_GLOBAL_UPD]; // RQ8
				end else begin
					if (i_global_update_set[g])
						tim_armed_reg <= 1'b1; // RQ9
					if (tim_busy_reg && tim_armed_reg && zero_evt) begin
						o_tim_active[g] <= tim_pend_reg; // RQ8 RQ9
						tim_busy_reg <= 1'b0;
					end
				end
			end

			// dead-band settings with optional sync
			pdsf_pkg::pdsf_db_s db_reg;
			pdsf_pkg::pdsf_db_s db_pend_reg;
			logic db_busy_reg;
			logic db_armed_reg;
			logic [1:0] db_mode;
			assign db_mode = i_db_upd_mode[g*2 +: 2];
			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					db_reg <= '0;
					db_pend_reg <= '0;
					db_busy_reg <= 1'b0;
					db_armed_reg <= 1'b0;
				end else if (i_db_wr[g] &&
				             db_mode == pdsf_pkg::PDSF_UPD_IMMED) begin
					db_reg <= i_db_wdata[g]; // RQ7 RQ11
					db_busy_reg <= 1'b0;
				end else if (i_db_wr[g]) begin
					db_pend_reg <= i_db_wdata[g];
					db_busy_reg <= 1'b1;
					db_armed_reg <= (db_mode == pdsf_pkg::PDSF_UPD_LOCAL);
				end else begin
					if (i_global_update_set[g])
						db_armed_reg <= 1'b1;
					if (db_busy_reg && db_armed_reg && zero_evt) begin
						db_reg <= db_pend_reg;
						db_busy_reg <= 1'b0;
					end
				end
			end

			// dead-band: count clocks since last input edge
			logic raw_a_reg;
			logic [CW-1:0] db_cnt_reg;
			logic raw_a;
			assign raw_a = i_raw_signal[2*g];
			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					raw_a_reg <= 1'b0;
					db_cnt_reg <= '0;
				end else begin
					raw_a_reg <= raw_a;
					if (raw_a != raw_a_reg)
						db_cnt_reg <= {{(CW-1){1'b0}}, 1'b1};
					else if (db_cnt_reg != {CW{1'b1}})
						db_cnt_reg <= db_cnt_reg + 1'b1; // RQ24
				end
			end
			logic dly_done_rise;
			logic dly_done_fall;
			logic [1:0] db_out;
			assign dly_done_rise = (raw_a == raw_a_reg) &&
			                       (db_cnt_reg >= db_reg.rise);
			assign dly_done_fall = (raw_a == raw_a_reg) &&
			                       (db_cnt_reg >= db_reg.fall);
			always_comb begin
				if (db_reg.enable) begin
					db_out[0] = raw_a & (dly_done_rise ||
					            db_reg.rise == '0); // RQ2
					db_out[1] = ~raw_a & (dly_done_fall ||
					            db_reg.fall == '0); // RQ3
				end else begin
					db_out = i_raw_signal[2*g +: 2]; // RQ1
				end
			end

			// fault detection, latch and minimum duration
			logic [NUM_FLT-1:0] src_mask;
			logic [NUM_FLT-1:0] hit;
			logic ext_flt;
			logic [CW-1:0] min_cnt_reg;
			logic latch_reg;
			logic [NUM_FLT-1:0] cause_reg;
			assign src_mask = ctl[pdsf_pkg::CTL_ALL_FLT] ?
			                  i_fault_source_select_reg[g*NUM_FLT +: NUM_FLT] :
			                  {{(NUM_FLT-1){1'b0}}, 1'b1}; // RQ13
			assign hit = flt_true & src_mask; // RQ17
			assign ext_flt = |hit;
			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					min_cnt_reg <= '0;
					latch_reg <= 1'b0;
					cause_reg <= '0;
				end else begin
					if (ext_flt && ctl[pdsf_pkg::CTL_MINPER_EN])
						min_cnt_reg <= i_min_fault_duration_reg[g*CW +: CW]; // RQ15
					else if (min_cnt_reg != '0)
						min_cnt_reg <= min_cnt_reg - 1'b1;
					// a new fault wins over a clear in the same cycle
					if (ext_flt && ctl[pdsf_pkg::CTL_LATCH])
						latch_reg <= 1'b1; // RQ14
					else if (i_fault_clear[g])
						latch_reg <= 1'b0;
					if (ext_flt)
						cause_reg <= cause_reg | hit; // RQ18
					else if (i_fault_clear[g] || !ctl[pdsf_pkg::CTL_LATCH])
						cause_reg <= '0;
				end
			end
			assign flt_any[g] = ext_flt || latch_reg || min_cnt_reg != '0 ||
			                    (i_debug_stall & i_stall_fault_en[g]); // RQ12

			// fault override, gate, then inversion last; a local pair
			// keeps each generator's process the only writer of its bits
			logic [1:0] pin_g;
			always_comb begin
				for (int k = 0; k < 2; k++) begin
					pin_g[k] = (i_fault_override_select_reg[2*g+k] &&
					            flt_any[g]) ?
					           i_fault_drive_value_reg[2*g+k] :
					           db_out[k]; // RQ20
					pin_g[k] = (pin_g[k] & gate_reg[2*g+k]) ^
					           i_invert_reg[2*g+k]; // RQ21 RQ22
				end
			end
			assign pin_next[2*g +: 2] = pin_g;
		end
	endgenerate

	// registered outputs
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_pwm_pin <= '0;
			o_fault_active <= '0;
			o_fault_irq <= 1'b0;
		end else begin
			o_pwm_pin <= pin_next;
			o_fault_active <= flt_any;
			o_fault_irq <= |(flt_any & i_module_irq_enable_reg); // RQ19
		end
	end

	generate
		for (g = 0; g < NUM_GEN; g++) begin : cause_out
			assign o_fault_cause_reg[g*NUM_FLT +: NUM_FLT] =
			       gen_blk[g].cause_reg;
		end
	endgenerate
endmodule

// >>> tb/pdsf_output_stage_properties.sv
// timing checks on the pwm back end, seen only at its top ports
// assumes default generic widths: two generators, four fault pins
`timescale 1ns/1ns
module pdsf_output_stage_props (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [11:0] i_counter_event,
	input wire logic [1:0] i_updown_mode,
	input wire logic [3:0] i_fault_input_pin,
	input wire logic i_time_base_sync_wr,
	input wire logic [1:0] i_time_base_sync_reg,
	input wire logic [7:0] i_generator_control_reg,
	input wire logic [7:0] i_fault_source_select_reg,
	input wire logic [3:0] i_fault_polarity_reg,
	input wire logic [1:0] i_fault_clear,
	input wire logic [11:0] i_irq_event_sel,
	input wire logic [11:0] i_adc_event_sel,
	input wire logic [1:0] o_counter_reset,
	input wire logic [1:0] o_gen_irq,
	input wire logic [1:0] o_adc_trigger,
	input wire logic [1:0] o_fault_active
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// pin 0 asserted, active high and selected for generator 0
	sequence s_pin0;
		i_fault_input_pin[0] && !i_fault_polarity_reg[0]
			&& i_fault_source_select_reg[0];
	endsequence
	// down-count events are always live; up matches only in up/down mode
	AST_SYNC: assert property (i_time_base_sync_wr |=>
		o_counter_reset == $past(i_time_base_sync_reg))
		else $error("counter reset does not match sync bits");
	AST_SYNC_NONE: assert property (!i_time_base_sync_wr |=>
		o_counter_reset == 2'h0)
		else $error("counter reset without sync write");
	AST_IRQ_SET: assert property (
		|(i_counter_event[5:0] & i_irq_event_sel[5:0] & 6'h2B) |=>
		o_gen_irq[0])
		else $error("selected event gave no interrupt");
	AST_IRQ_CLR: assert property (
		!(|(i_counter_event[5:0] & i_irq_event_sel[5:0])) |=>
		!o_gen_irq[0])
		else $error("interrupt without selected event");
	AST_ADC_SET: assert property (
		|(i_counter_event[5:0] & i_adc_event_sel[5:0] & 6'h2B) |=>
		o_adc_trigger[0])
		else $error("selected event gave no adc trigger");
	AST_ADC_CLR: assert property (
		!(|(i_counter_event[5:0] & i_adc_event_sel[5:0])) |=>
		!o_adc_trigger[0])
		else $error("adc trigger without selected event");
	AST_UPMASK: assert property (!i_updown_mode[0] &&
		(i_counter_event[5:0] & i_irq_event_sel[5:0]) == 6'h04 |=>
		!o_gen_irq[0])
		else $error("up match counted in down mode");
	AST_FAULT_RISE: assert property (s_pin0 [*3] |=>
		o_fault_active[0])
		else $error("fault pin did not raise fault in time");
	// the registered status lags the latch by one cycle after a clear
	AST_FAULT_LATCH: assert property (o_fault_active[0] &&
		i_generator_control_reg[2] && !i_fault_clear[0] &&
		!$past(i_fault_clear[0]) |=> o_fault_active[0])
		else $error("latched fault dropped without clear");
endmodule
bind pdsf_output_stage pdsf_output_stage_props u_props (.i_mclk(i_mclk),
	.i_rst(i_rst), .i_counter_event(i_counter_event),
	.i_updown_mode(i_updown_mode), .i_fault_input_pin(i_fault_input_pin),
	.i_time_base_sync_wr(i_time_base_sync_wr),
	.i_time_base_sync_reg(i_time_base_sync_reg),
	.i_generator_control_reg(i_generator_control_reg),
	.i_fault_source_select_reg(i_fault_source_select_reg),
	.i_fault_polarity_reg(i_fault_polarity_reg), .i_fault_clear(i_fault_clear),
	.i_irq_event_sel(i_irq_event_sel), .i_adc_event_sel(i_adc_event_sel),
	.o_counter_reset(o_counter_reset), .o_gen_irq(o_gen_irq),
	.o_adc_trigger(o_adc_trigger), .o_fault_active(o_fault_active));

// >>> tb/pdsf_fault_src.sv
// external fault sources facing the fault pins
// assumes each source's idle level is the inverse of its active level
`timescale 1ns/1ns
module pdsf_fault_src (
	input wire logic [3:0] i_req,
	input wire logic [3:0] i_pol,
	output logic [3:0] o_pin
);
	// an active-low source pulls its pin low only while it reports
	assign o_pin = i_req ^ i_pol;
endmodule

// >>> tb/pdsf_output_stage_tb_top.sv
// directed tests of the pwm back end through its port-level registers
// assumes pdsf_pkg defaults and the fault source model beside it
`timescale 1ns/1ns
module pdsf_output_stage_tb_top;
	logic clk = 1'b0, rst = 1'b1, sync_wr = 1'b0, gate_wr = 1'b0;
	logic [3:0] raw = 4'h0, freq = 4'h0, pol = 4'h0, gate = 4'h0;
	logic [3:0] inv = 4'h0, ovr = 4'h0, fval = 4'h0, pins, fpin;
	logic [11:0] ev = 12'h000, isel = 12'h005, asel = 12'h002;
	logic [7:0] ctl = 8'h00, fsel = 8'h00, cause;
	logic [1:0] sync = 2'h0, gus = 2'h0, twr = 2'h0, dwr = 2'h0, gum = 2'h0;
	logic [1:0] fclr = 2'h0, ien = 2'h0, crst, irq, adc, fact;
	logic firq;
	logic dbg = 1'b0;
	logic [1:0] udm = 2'h0;
	logic [3:0] dum = 4'h0;
	logic [31:0] mfp = 32'h00000000;
	pdsf_pkg::pdsf_tim_s [1:0] tw = '0;
	pdsf_pkg::pdsf_tim_s [1:0] tact;
	pdsf_pkg::pdsf_db_s [1:0] dw = '0;
	int mismatches = 0, n_compared = 0, cyc = 0;
	always #2 clk = ~clk;
	pdsf_fault_src u_src (.i_req(freq), .i_pol(pol), .o_pin(fpin));
	pdsf_output_stage u_dut (.i_mclk(clk), .i_rst(rst), .i_raw_signal(raw),
		.i_counter_event(ev), .i_updown_mode(udm), .i_fault_input_pin(fpin),
		.i_debug_stall(dbg), .i_stall_fault_en(2'h2),
		.i_time_base_sync_wr(sync_wr), .i_time_base_sync_reg(sync),
		.i_generator_control_reg(ctl), .i_global_update_set(gus),
		.i_tim_wr(twr), .i_tim_wdata(tw), .i_db_wr(dwr), .i_db_wdata(dw),
		.i_db_upd_mode(dum), .i_gate_wr(gate_wr), .i_output_gate_reg(gate),
		.i_gate_upd_mode(gum), .i_invert_reg(inv),
		.i_fault_override_select_reg(ovr), .i_fault_drive_value_reg(fval),
		.i_fault_source_select_reg(fsel), .i_fault_polarity_reg(pol),
		.i_min_fault_duration_reg(mfp), .i_fault_clear(fclr),
		.i_module_irq_enable_reg(ien), .i_irq_event_sel(isel),
		.i_adc_event_sel(asel), .o_pwm_pin(pins), .o_counter_reset(crst),
		.o_tim_active(tact), .o_gen_irq(irq), .o_adc_trigger(adc),
		.o_fault_irq(firq), .o_fault_active(fact), .o_fault_cause_reg(cause));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] e, g);
		n_compared++;
		if (e !== g) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	// one-cycle event pulse on generator 0; irq and adc trigger are due on return, pins a cycle later
	task automatic ev0(input logic [5:0] e);
		ev[5:0] = e;
		step(1);
		ev[5:0] = 6'h00;
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// a hung test cannot pass: the ceiling counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		step(2);
		rst = 1'b0;
		chk("pins after reset", 4'h0, pins);
		gate = 4'hF; gate_wr = 1'b1; raw = 4'h6; step(1); gate_wr = 1'b0; step(2);
		chk("passthrough", 4'h6, pins);
		inv = 4'h5; step(2);
		chk("inverted", 4'h3, pins);
		inv = 4'h0; gum = 2'h1; gate = 4'h0; gate_wr = 1'b1; step(1);
		gate_wr = 1'b0; step(3);
		chk("gate pending", 4'h6, pins);
		ev0(6'h01); step(2);
		chk("gate at zero", 4'h0, pins);
		gum = 2'h0; gate = 4'hF; gate_wr = 1'b1; step(1); gate_wr = 1'b0;
		$display("test output stage done");
		raw = 4'h2; dw[0] = '{1'b1, 16'h0003, 16'h0005}; dwr = 2'h1; step(1);
		dwr = 2'h0; step(10);
		chk("db idle", 2'h2, pins[1:0]);
		raw = 4'h1; step(3);
		chk("db rise gap", 2'h0, pins[1:0]);
		step(1);
		chk("db first high", 2'h1, pins[1:0]);
		raw = 4'h2; step(5);
		chk("db fall gap", 2'h0, pins[1:0]);
		step(1);
		chk("db second high", 2'h2, pins[1:0]);
		raw = 4'h3; dum = 4'h1; dw[0].enable = 1'b0; dwr = 2'h1; step(1);
		dwr = 2'h0; step(4);
		chk("db local pending", 2'h1, pins[1:0]);
		ev0(6'h01); step(1);
		chk("db local applied", 2'h3, pins[1:0]);
		dum = 4'h0;
		$display("test dead band done");
		tw[0] = '{16'h1234, 16'h0011, 16'h0022}; twr = 2'h1; step(1);
		twr = 2'h0; step(3);
		chk("load pending", 16'h0000, tact[0].load);
		ev0(6'h01);
		chk("irq on zero", 2'h1, irq);
		chk("no adc on zero", 2'h0, adc);
		step(1);
		chk("load at zero", 16'h1234, tact[0].load);
		chk("cmpb at zero", 16'h0022, tact[0].cmpb);
		chk("cmpa at zero", 16'h0011, tact[0].cmpa);
		ctl = 8'h01; tw[0].load = 16'h5678; twr = 2'h1; step(1); twr = 2'h0;
		ev0(6'h01); step(1);
		chk("global waits", 16'h1234, tact[0].load);
		gus = 2'h1; step(1); gus = 2'h0; step(2);
		chk("global armed", 16'h1234, tact[0].load);
		ev0(6'h01); step(1);
		chk("global applied", 16'h5678, tact[0].load);
		ev0(6'h02);
		chk("adc on load", 2'h1, adc);
		ev0(6'h04);
		chk("up match masked", 2'h0, irq);
		udm = 2'h1; ev0(6'h04);
		chk("up match counted", 2'h1, irq);
		udm = 2'h0;
		sync = 2'h3; sync_wr = 1'b1; step(1); sync_wr = 1'b0;
		chk("sync both", 2'h3, crst);
		$display("test update and events done");
		raw = 4'hA; fsel = 8'h01; ovr = 4'h3; fval = 4'h1; ien = 2'h1;
		ctl = 8'h04; freq = 4'h1; step(6);
		chk("fault pins", 4'h9, pins);
		chk("fault gen", 2'h3, fact);
		chk("fault cause", 8'h11, cause);
		chk("fault irq", 1'b1, firq);
		freq = 4'h0; step(6);
		chk("fault latched", 2'h1, fact);
		fclr = 2'h1; step(1); fclr = 2'h0; step(3);
		chk("fault cleared", 2'h0, fact);
		chk("pins restored", 4'hA, pins);
		pol = 4'h2; fsel = 8'h20; step(4); freq = 4'h2; step(6);
		chk("fault zero only", 2'h0, fact);
		ctl = 8'h20; step(3);
		chk("all faults low pin", 2'h2, fact);
		chk("cause gen1", 8'h20, cause);
		$display("test fault done");
		ctl = 8'h08; mfp = 32'h00000006; freq = 4'h1; step(1);
		freq = 4'h0; step(8);
		chk("min period held", 2'h1, fact);
		step(1);
		chk("min period ended", 2'h0, fact);
		dbg = 1'b1; step(1);
		chk("stall fault", 2'h2, fact);
		dbg = 1'b0; step(1);
		chk("stall gone", 2'h0, fact);
		$display("test minimum period and stall done");
		give_verdict();
	end
endmodule
